// *** logic/sef_device.sv ***
// How it works
// - serial clock is only an input; slave
// - bytes shift most significant bit first
// - first byte after select is opcode
// - opcode bit three is address bit nine
// - bad opcode: ignore input, output off
// - deselected: ignore input, output off
// - hold only pauses an active sequence
// - master lowers hold while clock low
// - master raises hold while clock low
// - held: output off, input ignored
// - write protect low blocks all writes
// - protect falling mid write aborts it
// - started programming always completes
// - supports clock idle low or high
// - programming self timed, bounded length
`timescale 1ns/100ps
module sef_device #(
	parameter int TWC_CYC = sef_pkg::TWC_CYC
) (
	input wire logic clk_sys,
	input wire logic reset,
	sef_link_if.dev link,
	output logic busy,
	output logic [8:0] wr_addr,
	output logic [7:0] wr_data,
	output logic wr_strobe
);
	typedef enum {ST_IDLE, ST_OPC, ST_ADDR, ST_DATA, ST_RDOUT, ST_SROUT,
		ST_SRIN, ST_DEAD} sef_st_t;
	// two flops on each pin before any logic looks at it
	logic [1:0] sck_s_q, cs_s_q, si_s_q, hold_s_q, wp_s_q;
	logic sck_prev_q, cs_prev_q;
	sef_st_t st_q, st_d;
	logic [2:0] bit_q, bit_d;
	logic [7:0] sh_q, sh_d, out_q, out_d;
	logic [8:0] addr_q, addr_d;
	logic [7:0] dat_q, dat_d;
	logic wen_q, wen_d, pend_q, pend_d, so_q, so_d, oe_q, oe_d;
	logic [7:0] sr_q, sr_d;
	logic [31:0] cnt_q, cnt_d;
	logic busy_q, busy_d, stb_q, stb_d, held_q, held_d;
	logic wrop_q, wrop_d;
	logic sck, cs, si, hold_ok, wp_ok, rise, fall, sel_fall;
	logic [7:0] byte_in;

	// synchronisers
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			sck_s_q <= '0;
			cs_s_q <= 2'b11;
			si_s_q <= '0;
			hold_s_q <= 2'b11;
			wp_s_q <= 2'b11;
			sck_prev_q <= 1'b0;
			cs_prev_q <= 1'b1;
		end else begin
			sck_s_q <= {sck_s_q[0], link.sck};
			cs_s_q <= {cs_s_q[0], link.cs_n};
			si_s_q <= {si_s_q[0], link.si};
			hold_s_q <= {hold_s_q[0], link.hold_n};
			wp_s_q <= {wp_s_q[0], link.wp_n};
			sck_prev_q <= sck_s_q[1];
			cs_prev_q <= cs_s_q[1];
		end
	end

	assign sck = sck_s_q[1];
	assign cs = cs_s_q[1];
	assign si = si_s_q[1];
	assign hold_ok = hold_s_q[1];
	assign wp_ok = wp_s_q[1];
	// edge logic is polarity-free, so idle-high clock works too
	assign rise = sck & ~sck_prev_q & ~cs & ~held_q;
	assign fall = ~sck & sck_prev_q & ~cs & ~held_q;
	assign sel_fall = ~cs & cs_prev_q;
	assign byte_in = {sh_q[6:0], si};

	// serial sequence, hold, programming timer
	always_comb begin
		st_d = st_q;
		bit_d = bit_q;
		sh_d = sh_q;
		out_d = out_q;
		addr_d = addr_q;
		dat_d = dat_q;
		wen_d = wen_q;
		pend_d = pend_q;
		so_d = so_q;
		oe_d = oe_q;
		sr_d = sr_q;
		cnt_d = cnt_q;
		busy_d = busy_q;
		stb_d = 1'b0;
		held_d = held_q;
		wrop_d = wrop_q;
		// hold honoured only with clock low inside a live sequence
		if (cs || st_q == ST_IDLE || st_q == ST_DEAD)
			held_d = 1'b0;
		else if (!sck)
			held_d = ~hold_ok;
		if (busy_q) begin
			// runs to the end whatever write protect does
			if (cnt_q == 32'(TWC_CYC - 1)) begin
				busy_d = 1'b0;
				wen_d = 1'b0;
				cnt_d = '0;
			end else begin
				cnt_d = cnt_q + 32'd1;
			end
		end
		if (cs) begin
			// rising select launches a complete, unprotected write
			if (pend_q && bit_q == 3'd0 && wp_ok && !busy_q) begin
				busy_d = 1'b1;
				stb_d = 1'b1;
				cnt_d = '0;
			end
			pend_d = 1'b0;
			st_d = ST_IDLE;
			oe_d = 1'b0;
		end else if (sel_fall) begin
			st_d = ST_OPC;
			bit_d = '0;
			sh_d = '0;
		end
		if (!cs && !wp_ok)
			pend_d = 1'b0;
		if (rise) begin
			sh_d = byte_in;
			bit_d = bit_q + 3'd1;
			if (bit_q == 3'd7) begin
				case (st_q)
				ST_OPC: begin
					st_d = ST_DEAD;
					// remembered apart from out_q, which a status read rotates
					wrop_d = byte_in[2:0] == sef_pkg::OP_WRITE;
					if (byte_in[7:4] == sef_pkg::OP_HI && !busy_q) begin
						addr_d = {byte_in[sef_pkg::OP_A9_BIT], 8'h00};
						case (byte_in[2:0])
						sef_pkg::OP_WREN: wen_d = 1'b1;
						sef_pkg::OP_WRDI: wen_d = 1'b0;
						sef_pkg::OP_RDSR: st_d = ST_SROUT;
						sef_pkg::OP_WRSR: st_d = wen_q ? ST_SRIN : ST_DEAD;
						sef_pkg::OP_READ: st_d = ST_ADDR;
						sef_pkg::OP_WRITE: st_d = wen_q ? ST_ADDR : ST_DEAD;
						default: st_d = ST_DEAD;
						endcase
						if (byte_in[2:0] == sef_pkg::OP_WRITE)
							pend_d = 1'b0;
						// status: protect bits, write enable, busy
						out_d = {sr_q[7:2], wen_q, busy_q};
					end else if (byte_in[7:4] == sef_pkg::OP_HI &&
						byte_in[2:0] == sef_pkg::OP_RDSR) begin
						// only a status read gets through while programming
						st_d = ST_SROUT;
						out_d = {4'hf, sr_q[3:2], wen_q, 1'b1};
					end
				end
				ST_ADDR: begin
					addr_d = {addr_q[8], byte_in};
					st_d = wrop_q ? ST_DATA : ST_RDOUT;
					out_d = 8'h00;
				end
				ST_DATA: begin
					dat_d = byte_in;
					pend_d = wp_ok;
				end
				ST_SRIN: begin
					if (wp_ok)
						sr_d = {4'h0, byte_in[3:2], 2'b00};
				end
				ST_RDOUT: addr_d = addr_q + 9'd1;
				default: st_d = st_q;
				endcase
			end
		end
		if (fall && (st_q == ST_SROUT || st_q == ST_RDOUT)) begin
			so_d = out_q[7];
			out_d = {out_q[6:0], out_q[7]};
		end
		// output off when deselected, held or after a bad opcode
		oe_d = !cs && !held_d && (st_q == ST_SROUT || st_q == ST_RDOUT);
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			st_q <= ST_IDLE;
			bit_q <= '0;
			sh_q <= '0;
			out_q <= '0;
			addr_q <= '0;
			dat_q <= '0;
			wen_q <= 1'b0;
			pend_q <= 1'b0;
			so_q <= 1'b0;
			oe_q <= 1'b0;
			sr_q <= sef_pkg::SR_RESET;
			cnt_q <= '0;
			busy_q <= 1'b0;
			stb_q <= 1'b0;
			held_q <= 1'b0;
			wrop_q <= 1'b0;
		end else begin
			st_q <= st_d;
			bit_q <= bit_d;
			sh_q <= sh_d;
			out_q <= out_d;
			addr_q <= addr_d;
			dat_q <= dat_d;
			wen_q <= wen_d;
			pend_q <= pend_d;
			so_q <= so_d;
			oe_q <= oe_d;
			sr_q <= sr_d;
			cnt_q <= cnt_d;
			busy_q <= busy_d;
			stb_q <= stb_d;
			held_q <= held_d;
			wrop_q <= wrop_d;
		end
	end

	assign link.so = so_q;
	assign link.so_oe = oe_q;
	assign busy = busy_q;
	assign wr_addr = addr_q;
	assign wr_data = dat_q;
	assign wr_strobe = stb_q;
endmodule

// *** logic/sef_host.sv ***
`timescale 1ns/100ps
module sef_host (
	input wire logic clk_sys,
	input wire logic reset,
	sef_link_if.host link,
	input wire logic start,
	input wire logic [7:0] tx_byte,
	input wire logic last,
	input wire logic pause,
	input wire logic protect_n,
	output logic ready,
	output logic [7:0] rx_byte,
	output logic rx_valid
);
	typedef enum {HS_IDLE, HS_SHIFT, HS_GAP} sef_hst_t;
	localparam logic [1:0] DIV_END = 2'(sef_pkg::SCK_DIV - 1);
	sef_hst_t st_q, st_d;
	logic [1:0] div_q, div_d;
	logic [2:0] bit_q, bit_d;
	logic [7:0] tx_q, tx_d, rx_q, rx_d;
	logic sck_q, sck_d, cs_q, cs_d, hold_q, hold_d, last_q, last_d;
	logic rdy_q, rdy_d, val_q, val_d, si_q, si_d, wp_q;
	logic [1:0] so_s_q;

	// clock is made here by dividing, idle low (mode 0)
	always_comb begin
		st_d = st_q;
		div_d = div_q + 2'd1;
		bit_d = bit_q;
		tx_d = tx_q;
		rx_d = rx_q;
		sck_d = sck_q;
		cs_d = cs_q;
		hold_d = hold_q;
		last_d = last_q;
		rdy_d = rdy_q;
		val_d = 1'b0;
		si_d = si_q;
		// hold changes only while the clock sits low and is not about to
		// rise, so hold and clock never move on the same edge
		if (!sck_q && !(st_q == HS_SHIFT && div_q == DIV_END))
			hold_d = ~pause;
		case (st_q)
		HS_IDLE: begin
			if (start && rdy_q) begin
				cs_d = 1'b0;
				tx_d = tx_byte;
				si_d = tx_byte[7];
				last_d = last;
				bit_d = '0;
				rdy_d = 1'b0;
				div_d = '0;
				st_d = HS_SHIFT;
			end
		end
		HS_SHIFT: begin
			if (div_q == DIV_END && hold_q) begin
				sck_d = ~sck_q;
				if (sck_q) begin
					// so is taken late, at the falling edge: the trip through
					// both synchronisers outlasts half a clock period
					rx_d = {rx_q[6:0], so_s_q[1]};
					tx_d = {tx_q[6:0], 1'b0};
					si_d = tx_q[6];
					bit_d = bit_q + 3'd1;
					if (bit_q == 3'd7) begin
						val_d = 1'b1;
						rdy_d = 1'b1;
						st_d = HS_GAP;
					end
				end
			end
		end
		HS_GAP: begin
			if (last_q) begin
				cs_d = 1'b1;
				st_d = HS_IDLE;
			end else if (start) begin
				tx_d = tx_byte;
				si_d = tx_byte[7];
				last_d = last;
				rdy_d = 1'b0;
				div_d = '0;
				st_d = HS_SHIFT;
			end
		end
		default: st_d = HS_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			st_q <= HS_IDLE;
			div_q <= '0;
			bit_q <= '0;
			tx_q <= '0;
			rx_q <= '0;
			sck_q <= 1'b0;
			cs_q <= 1'b1;
			hold_q <= 1'b1;
			last_q <= 1'b0;
			rdy_q <= 1'b1;
			val_q <= 1'b0;
			si_q <= 1'b0;
			wp_q <= 1'b1;
			so_s_q <= '0;
		end else begin
			st_q <= st_d;
			div_q <= div_d;
			bit_q <= bit_d;
			tx_q <= tx_d;
			rx_q <= rx_d;
			sck_q <= sck_d;
			cs_q <= cs_d;
			hold_q <= hold_d;
			last_q <= last_d;
			rdy_q <= rdy_d;
			val_q <= val_d;
			si_q <= si_d;
			wp_q <= protect_n;
			so_s_q <= {so_s_q[0], link.so};
		end
	end

	assign link.sck = sck_q;
	assign link.cs_n = cs_q;
	assign link.si = si_q;
	assign link.hold_n = hold_q;
	assign link.wp_n = wp_q;
	assign ready = rdy_q;
	assign rx_byte = rx_q;
	assign rx_valid = val_q;
endmodule

// *** logic/sef_link_if.sv ***
`timescale 1ns/100ps
interface sef_link_if;
	logic sck;
	logic cs_n;
	logic si;
	logic so;
	logic so_oe;
	logic hold_n;
	logic wp_n;
	modport dev (input sck, input cs_n, input si, input hold_n, input wp_n,
		output so, output so_oe);
	modport host (output sck, output cs_n, output si, output hold_n,
		output wp_n, input so, input so_oe);
endinterface

// *** logic/sef_pkg.sv ***
package sef_pkg;
	// opcode layout: upper nibble zero, bit 3 carries address_bit_nine
	localparam logic [3:0] OP_HI = 4'h0;
	localparam int OP_A9_BIT = 3;
	localparam logic [2:0] OP_WREN = 3'h6;
	localparam logic [2:0] OP_WRDI = 3'h4;
	localparam logic [2:0] OP_RDSR = 3'h5;
	localparam logic [2:0] OP_WRSR = 3'h1;
	localparam logic [2:0] OP_READ = 3'h3;
	localparam logic [2:0] OP_WRITE = 3'h2;
	// timing
	localparam int CLK_NS = 40;
	localparam int TWC_MS = 5;
	localparam int TWC_CYC = TWC_MS * 1000000 / CLK_NS;
	localparam int SCK_DIV = 4;
	localparam logic [7:0] SR_RESET = 8'h00;
endpackage

// *** tb/sef_link_asserts.sv ***
`timescale 1ns/100ps
module sef_link_asserts (
	input logic clk_sys,
	input logic reset,
	input logic sck,
	input logic cs_n,
	input logic si,
	input logic so,
	input logic so_oe,
	input logic hold_n,
	input logic wp_n
);
	// one clock domain, so one default clock and reset
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	// output off once deselection has passed the synchroniser and flop
	desel_off_a: assert property (cs_n[*4] |-> !so_oe)
		else $error("so driven while deselected");
	// held a few cycles: output must be off, allows the synchroniser
	hold_off_a: assert property ((!hold_n)[*4] |-> !so_oe)
		else $error("so driven during hold");
	hold_fall_a: assert property ($fell(hold_n) |-> !sck)
		else $error("hold lowered with clock high");
	hold_rise_a: assert property ($rose(hold_n) |-> !sck)
		else $error("hold raised with clock high");
	// so moves only after falling clock edges
	so_steady_a: assert property ((sck && so_oe)[*3] |-> $stable(so))
		else $error("so changed while clock high");
	si_steady_a: assert property (sck && $past(sck) |-> $stable(si))
		else $error("si changed while clock high");
	sel_edge_a: assert property ($fell(cs_n) |-> !sck)
		else $error("select fell with clock high");
	desel_edge_a: assert property ($rose(cs_n) |-> !sck)
		else $error("select rose with clock high");
	// so stays off for the first eight system clocks after select falls, early in the opcode byte
	opcode_quiet_a: assert property ($fell(cs_n) |-> (!so_oe)[*8])
		else $error("so driven during opcode");
	// clock comes from the host divider, four cycles per phase
	sck_rate_a: assert property ($changed(sck) |=> $stable(sck)[*3])
		else $error("serial clock phase too short");
endmodule

// *** tb/spi_eeprom_serial_front_end_bench.sv ***
`timescale 1ns/100ps
module spi_eeprom_serial_front_end_bench;
	typedef struct packed {logic a9; logic [7:0] ad; logic [7:0] dt;} sef_row_t;
	localparam sef_row_t ROWS [4] = '{'{1'b0, 8'h00, 8'hA5},
		'{1'b1, 8'hFF, 8'h5A}, '{1'b1, 8'h80, 8'h01}, '{1'b0, 8'h7F, 8'h80}};
	localparam logic [7:0] WREN = {sef_pkg::OP_HI, 1'b0, sef_pkg::OP_WREN};
	logic clk_sys, reset, start, last, pause, protect_n, ready, rx_valid;
	logic busy, wr_strobe;
	logic [7:0] tx_byte, rx_byte, wr_data, rx, s_data;
	logic [8:0] wr_addr, s_addr;
	int num_errors, checked, n_stb, cyc, k;
	sef_link_if sef_link_if_i ();
	// short programming time keeps the run brief
	sef_device #(.TWC_CYC(50)) sef_device_i (.clk_sys(clk_sys),
		.reset(reset), .link(sef_link_if_i.dev), .busy(busy),
		.wr_addr(wr_addr), .wr_data(wr_data), .wr_strobe(wr_strobe));
	sef_host sef_host_i (.clk_sys(clk_sys), .reset(reset),
		.link(sef_link_if_i.host), .start(start), .tx_byte(tx_byte),
		.last(last), .pause(pause), .protect_n(protect_n), .ready(ready),
		.rx_byte(rx_byte), .rx_valid(rx_valid));
	sef_link_asserts sef_link_asserts_i (.clk_sys(clk_sys), .reset(reset),
		.sck(sef_link_if_i.sck), .cs_n(sef_link_if_i.cs_n),
		.si(sef_link_if_i.si), .so(sef_link_if_i.so),
		.so_oe(sef_link_if_i.so_oe), .hold_n(sef_link_if_i.hold_n),
		.wp_n(sef_link_if_i.wp_n));
	initial begin
		clk_sys = 0;
		forever #20 clk_sys = ~clk_sys;
	end
	// capture every programming start
	always @(posedge clk_sys) begin
		if (wr_strobe === 1'b1) begin
			n_stb++;
			s_addr = wr_addr;
			s_data = wr_data;
		end
	end
	// hang guard, well above the expected few thousand cycles
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 30000) begin
			num_errors++;
			complete_run();
		end
	end
	task chk(input string nm, input logic [8:0] e, input logic [8:0] g);
		checked++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
			num_errors++;
		end
	endtask
	task complete_run();
		$display("checked %0d num_errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// one byte; pz asks for a hold pause in mid byte
	task xfer(input logic [7:0] b, input logic l, input logic pz);
		int n;
		@(posedge clk_sys);
		while (ready !== 1'b1) @(posedge clk_sys);
		start <= 1;
		tx_byte <= b;
		last <= l;
		@(posedge clk_sys);
		start <= 0;
		if (pz) begin
			repeat (18) @(posedge clk_sys);
			pause <= 1;
			repeat (40) @(posedge clk_sys);
			pause <= 0;
		end
		n = 0;
		while (rx_valid !== 1'b1 && n < 400) begin
			@(posedge clk_sys);
			n++;
		end
		chk("rx_valid", 9'h001, {8'h00, rx_valid});
		rx = rx_byte;
		if (l) repeat (8) @(posedge clk_sys);
	endtask
	// mid lowers protect before the data byte
	task wr(input logic a9, input logic [7:0] ad, input logic [7:0] dt,
		input logic pz, input logic mid);
		xfer(WREN, 1, 0);
		xfer({sef_pkg::OP_HI, a9, sef_pkg::OP_WRITE}, 0, 0);
		xfer(ad, 0, pz);
		if (mid) protect_n <= 0;
		xfer(dt, 1, 0);
	endtask
	task wait_idle();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 300) begin
			@(posedge clk_sys);
			n++;
		end
		chk("busy", 9'h000, {8'h00, busy});
	endtask
	initial begin
		reset = 1'b1;
		start = 1'b0;
		tx_byte = 8'h00;
		last = 1'b0;
		pause = 1'b0;
		protect_n = 1'b1;
		repeat (2) @(posedge clk_sys);
		reset <= 0;
		foreach (ROWS[i]) begin
			k = n_stb;
			wr(ROWS[i].a9, ROWS[i].ad, ROWS[i].dt, 0, 0);
			chk("strobes", 9'(k + 1), 9'(n_stb));
			chk("wr_addr", {ROWS[i].a9, ROWS[i].ad}, s_addr);
			chk("wr_data", {1'b0, ROWS[i].dt}, {1'b0, s_data});
			wait_idle();
			$display("test row %0d done", i);
		end
		// status byte is paused in mid output, so so must go quiet
		xfer(WREN, 1, 0);
		xfer({sef_pkg::OP_HI, 1'b0, sef_pkg::OP_RDSR}, 0, 0);
		xfer(8'h00, 1, 1);
		chk("status", 9'h002, {1'b0, rx});
		$display("test status done");
		k = n_stb;
		wr(1, 8'h3C, 8'hC3, 1, 0);
		chk("hold addr", 9'h13C, s_addr);
		chk("hold data", 9'h0C3, {1'b0, s_data});
		wait_idle();
		$display("test hold done");
		k = n_stb;
		xfer(WREN, 1, 0);
		xfer(8'h12, 0, 0);
		xfer(8'h02, 0, 0);
		xfer(8'h05, 0, 0);
		xfer(8'h77, 1, 0);
		chk("bad op", 9'(k), 9'(n_stb));
		protect_n <= 0;
		wr(0, 8'h10, 8'h11, 0, 0);
		chk("wp low", 9'(k), 9'(n_stb));
		protect_n <= 1;
		wr(0, 8'h20, 8'h22, 0, 1);
		chk("wp mid", 9'(k), 9'(n_stb));
		protect_n <= 1;
		wr(0, 8'h30, 8'h33, 0, 0);
		protect_n <= 0;
		chk("wp late", 9'(k + 1), 9'(n_stb));
		chk("busy on", 9'h001, {8'h00, busy});
		wait_idle();
		protect_n <= 1;
		$display("test protect done");
		// reset again once idle, after the last programming has ended
		reset <= 1;
		repeat (2) @(posedge clk_sys);
		reset <= 0;
		@(posedge clk_sys);
		chk("so_oe", 9'h000, {8'h00, sef_link_if_i.so_oe});
		chk("cs_n", 9'h001, {8'h00, sef_link_if_i.cs_n});
		chk("ready", 9'h001, {8'h00, ready});
		$display("test reset done");
		complete_run();
	end
endmodule
